// [cnc_top.sv]
// Interrupt, coprocessor handshake and reset input logic of the core.
// Assumes a core sequencer that reports wait/escape execution, accepts
// vectored traps and runs operand transfers when asked.
`timescale 1ns/1ps
`default_nettype none
module cnc_top (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Pins in
  input  wire logic       nmi_in,
  input  wire logic       ext_operand_req_in,
  input  wire logic       busy_n_in,
  input  wire logic       error_n_in,
  // Pin out
  output logic            ext_operand_ack_n_out,
  // Core sequencer inputs
  input  wire logic       wait_instr_in,
  input  wire logic       escape_coproc_instr_in,
  input  wire logic       intr_pending_in,
  input  wire logic       operand_xfer_in,
  input  wire logic       trap_taken_in,
  // Core sequencer outputs
  output logic            operand_req_out,
  output logic            trap_req_out,
  output logic [7:0]      trap_vector_out,
  output logic            inta_cycle_out,
  output logic            stall_out,
  output logic            fetch_enable_out,
  output logic            reset_valid_out
);
  cnc_sync_if sif ();

  // State, counters and flags
  cnc_pkg::cnc_state_t state_ff;
  cnc_pkg::cnc_state_t nxt_state;
  logic [cnc_pkg::CNT_W-1:0] init_cnt_ff;
  logic [cnc_pkg::CNT_W-1:0] low_cnt_ff;
  logic [cnc_pkg::CNT_W-1:0] rst_cnt_ff;
  logic       nmi_q_ff;
  logic       nmi_armed_ff;
  logic       nmi_pend_ff;
  logic       err_pend_ff;
  logic       ack_n_ff;
  logic [7:0] vec_ff;

  // Synchronised pins and decoded terms
  logic       nmi_s;
  logic       busy_s;
  logic       error_s;
  logic       nmi_rise;
  logic       coproc_instr;
  // Trap flag terms and the vector's next value
  logic       err_set;
  logic       nmi_clr;
  logic       err_clr;
  logic [7:0] nxt_vec;

  // Pins into the synchroniser bank
  assign sif.raw[cnc_pkg::SYNC_NMI]     = nmi_in;
  assign sif.raw[cnc_pkg::SYNC_BUSY_N]  = busy_n_in;
  assign sif.raw[cnc_pkg::SYNC_ERROR_N] = error_n_in;

  cnc_sync u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .sif    (sif)
  );

  // Synchronised levels, active high inside
  assign nmi_s   = sif.synced[cnc_pkg::SYNC_NMI];
  assign busy_s  = ~sif.synced[cnc_pkg::SYNC_BUSY_N];
  assign error_s = ~sif.synced[cnc_pkg::SYNC_ERROR_N];
  assign coproc_instr = wait_instr_in | escape_coproc_instr_in;

  // Set and clear terms shared by the latches and the vector mux
  assign err_set = coproc_instr && error_s &&
                   state_ff == cnc_pkg::CNC_ST_RUN;
  assign nmi_clr = trap_taken_in && vec_ff == cnc_pkg::NMI_VECTOR;
  assign err_clr = trap_taken_in && vec_ff == cnc_pkg::COPROC_VECTOR;

  // Edge from synchronised samples, after enough low time
  assign nmi_rise = nmi_s & ~nmi_q_ff & nmi_armed_ff;

  // Delayed NMI sample; reset clears it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_q_ff <= 1'b0;
    end else begin
      nmi_q_ff <= nmi_s;
    end
  end

  // Low-time qualifier rejects short glitches
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_ff   <= cnc_pkg::CNT_ZERO;
      nmi_armed_ff <= 1'b0;
    end else if (nmi_s) begin
      low_cnt_ff   <= cnc_pkg::CNT_ZERO;
      if (!nmi_rise && nmi_q_ff)
        nmi_armed_ff <= 1'b0;
    end else begin
      if (low_cnt_ff != cnc_pkg::NMI_LOW_MIN)
        low_cnt_ff <= low_cnt_ff + cnc_pkg::CNT_ONE;
      if (low_cnt_ff + cnc_pkg::CNT_ONE >= cnc_pkg::NMI_LOW_MIN)
        nmi_armed_ff <= 1'b1;
    end
  end

  // NMI latch ignores the interrupt enable flag; set beats clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_pend_ff <= 1'b0;
    end else if (nmi_rise) begin
      nmi_pend_ff <= 1'b1;
    end else if (nmi_clr) begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // Error sampled when a coprocessor instruction executes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_pend_ff <= 1'b0;
    end else if (err_set) begin
      err_pend_ff <= 1'b1;
    end else if (err_clr) begin
      err_pend_ff <= 1'b0;
    end
  end

  // Vector chosen internally; NMI has priority
  // Follows the flags' next values, so a trap never shows a stale vector
  always_comb begin
    nxt_vec = vec_ff;
    if (nmi_rise || (nmi_pend_ff && !nmi_clr)) begin
      nxt_vec = cnc_pkg::NMI_VECTOR;
    end else if (err_set || (err_pend_ff && !err_clr)) begin
      nxt_vec = cnc_pkg::COPROC_VECTOR;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vec_ff <= cnc_pkg::NMI_VECTOR;
    end else begin
      vec_ff <= nxt_vec;
    end
  end

  // Sequencer: init count, run, wait on busy
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cnc_pkg::CNC_ST_INIT: begin
        if (init_cnt_ff == cnc_pkg::INIT_LAST)
          nxt_state = cnc_pkg::CNC_ST_RUN;
      end
      cnc_pkg::CNC_ST_RUN: begin
        if (coproc_instr && busy_s && !error_s)
          nxt_state = cnc_pkg::CNC_ST_WAIT;
      end
      cnc_pkg::CNC_ST_WAIT: begin
        // Interrupts break the wait
        if (!busy_s || nmi_pend_ff || intr_pending_in)
          nxt_state = cnc_pkg::CNC_ST_RUN;
      end
      default: nxt_state = cnc_pkg::CNC_ST_INIT;
    endcase
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= cnc_pkg::CNC_ST_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Init counter stops once running
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt_ff <= cnc_pkg::CNT_ZERO;
    end else if (state_ff == cnc_pkg::CNC_ST_INIT) begin
      init_cnt_ff <= init_cnt_ff + cnc_pkg::CNT_ONE;
    end
  end

  // Cycles since reset release counted up to RST_MIN; release assumed synchronous
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_cnt_ff <= cnc_pkg::CNT_ZERO;
    end else if (rst_cnt_ff != cnc_pkg::RST_MIN) begin
      rst_cnt_ff <= rst_cnt_ff + cnc_pkg::CNT_ONE;
    end
  end

  // Acknowledge low only during the operand transfer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_n_ff <= 1'b1;
    end else begin
      ack_n_ff <= ~(operand_xfer_in && ext_operand_req_in);
    end
  end

  // Outputs to pins and sequencer
  assign ext_operand_ack_n_out = ack_n_ff;
  assign operand_req_out  = ext_operand_req_in &&
                            state_ff != cnc_pkg::CNC_ST_INIT;
  assign trap_req_out     = nmi_pend_ff | err_pend_ff;
  assign trap_vector_out  = vec_ff;
  assign inta_cycle_out   = 1'b0;  // Internal vectors only
  assign stall_out        = state_ff == cnc_pkg::CNC_ST_WAIT;
  assign fetch_enable_out = state_ff != cnc_pkg::CNC_ST_INIT;

  // Cannot see reset length from inside an async reset; shows RST_MIN cycles since release
  assign reset_valid_out  = rst_cnt_ff == cnc_pkg::RST_MIN;
endmodule // cnc_top
`default_nettype wire

// [cnc_pkg.sv]
// Constants and types for the interrupt, coprocessor and reset input block.
// Assumes a single 100 MHz clock; no software-visible registers.
package cnc_pkg;
  localparam int unsigned NMI_VECTOR_NUM   = 2;
  localparam int unsigned COPROC_VECTOR_NUM = 16;
  localparam logic [7:0]  NMI_VECTOR       = 8'(NMI_VECTOR_NUM);
  localparam logic [7:0]  COPROC_VECTOR    = 8'(COPROC_VECTOR_NUM);
  localparam int unsigned NMI_LOW_CYC      = 4;
  localparam int unsigned NMI_HIGH_CYC     = 4;
  localparam int unsigned RST_MIN_CYC      = 16;
  localparam int unsigned INIT_CYC         = 38;
  localparam int unsigned CNT_W            = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 6'h01;
  localparam logic [CNT_W-1:0] NMI_LOW_MIN = CNT_W'(NMI_LOW_CYC);
  localparam logic [CNT_W-1:0] RST_MIN     = CNT_W'(RST_MIN_CYC);
  localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_CYC - 1);
  localparam int unsigned SYNC_BITS        = 3;
  localparam int unsigned SYNC_NMI         = 0;
  localparam int unsigned SYNC_BUSY_N      = 1;
  localparam int unsigned SYNC_ERROR_N     = 2;

  typedef enum logic [1:0] {
    CNC_ST_INIT = 2'b00,
    CNC_ST_RUN  = 2'b01,
    CNC_ST_WAIT = 2'b10
  } cnc_state_t;
endpackage

// [cnc_sync_if.sv]
// Carrier between the top block and its synchroniser bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cnc_sync_if;
  logic [cnc_pkg::SYNC_BITS-1:0] raw;
  logic [cnc_pkg::SYNC_BITS-1:0] synced;
  modport top  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface // cnc_sync_if
`default_nettype wire

// [cnc_sync.sv]
// Two-stage synchroniser bank for asynchronous pins.
// Assumes reset levels equal the inactive pin levels.
`timescale 1ns/1ps
`default_nettype none
module cnc_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pins in, synced out
  cnc_sync_if.sync  sif
);
  // Inactive levels: NMI low, busy and error high
  localparam logic [cnc_pkg::SYNC_BITS-1:0] IDLE = 3'h6;
  logic [cnc_pkg::SYNC_BITS-1:0] meta_ff;
  logic [cnc_pkg::SYNC_BITS-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < cnc_pkg::SYNC_BITS; i++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_ff[i] <= IDLE[i];
          sync_ff[i] <= IDLE[i];
        end else begin
          meta_ff[i] <= sif.raw[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_ff;
endmodule // cnc_sync
`default_nettype wire

// [cnc_checker.sv]
// Checker for the interrupt, coprocessor and reset block.
// Bound to cnc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cnc_checker (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       nmi_in,
  input wire logic       busy_n_in,
  input wire logic       error_n_in,
  input wire logic       wait_instr_in,
  input wire logic       escape_coproc_instr_in,
  input wire logic       intr_pending_in,
  input wire logic       operand_xfer_in,
  input wire logic       ext_operand_req_in,
  input wire logic       ext_operand_ack_n_out,
  input wire logic       trap_req_out,
  input wire logic [7:0] trap_vector_out,
  input wire logic       inta_cycle_out,
  input wire logic       stall_out,
  input wire logic       fetch_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] cyc_ff;
  logic       ins;
  assign ins = wait_instr_in | escape_coproc_instr_in;
  // Cycles since release; saturates so it never wraps
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) cyc_ff <= 6'h00;
    else if (cyc_ff != 6'h3f) cyc_ff <= cyc_ff + 6'h01;
  sequence s_nmi;
    !nmi_in [*4] ##1 nmi_in [*4];
  endsequence
  sequence s_busy;
    (!busy_n_in & error_n_in & !nmi_in & !intr_pending_in) [*3];
  endsequence
  sequence s_err;
    !error_n_in [*2] ##1 (!error_n_in & ins & fetch_enable_out
      & !trap_req_out & !nmi_in);
  endsequence
  a_nmi_vector: assert property (
    s_nmi |-> ##[0:2]
      (trap_req_out && trap_vector_out == cnc_pkg::NMI_VECTOR))
    else $error("nmi trap missing");
  a_no_inta: assert property (!inta_cycle_out)
    else $error("ack cycle seen");
  a_ack_xfer: assert property (
    operand_xfer_in & ext_operand_req_in & fetch_enable_out
    |=> !ext_operand_ack_n_out) else $error("ack missing");
  a_busy_stall: assert property (
    s_busy ##0 (wait_instr_in & fetch_enable_out) |=> stall_out)
    else $error("no stall");
  a_busy_clear: assert property (busy_n_in [*4] |=> !stall_out)
    else $error("stall stuck");
  a_intr_wake: assert property (
    stall_out & intr_pending_in & !ins |-> ##[1:3] !stall_out)
    else $error("intr ignored");
  a_err_vector: assert property (
    s_err |=> trap_req_out &&
      trap_vector_out == cnc_pkg::COPROC_VECTOR)
    else $error("error trap missing");
  a_init_len: assert property (
    cyc_ff < 6'h25 ? !fetch_enable_out
      : (cyc_ff < 6'h28 || fetch_enable_out))
    else $error("init length");
endmodule // cnc_checker
`default_nettype wire

// [cnc_coproc.sv]
// Behavioural coprocessor on the extension pins.
// Assumes bench commands; pins move just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cnc_coproc (
  // Clock and commands
  input  wire logic clk_in,
  input  wire logic busy_cmd_in,
  input  wire logic err_cmd_in,
  input  wire logic req_cmd_in,
  // Pins
  output logic      busy_n_out,
  output logic      error_n_out,
  output logic      req_out
);
  // Pulled-up lines idle high
  initial begin
    busy_n_out = 1'b1;
    error_n_out = 1'b1;
    req_out = 1'b0;
  end
  always @(posedge clk_in) begin
    busy_n_out <= !busy_cmd_in;
    error_n_out <= !err_cmd_in;
    req_out <= req_cmd_in;
  end
endmodule // cnc_coproc
`default_nettype wire

// [tb.sv]
// Bench for the interrupt, coprocessor and reset block.
// Assumes cnc_top, cnc_coproc and cnc_checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       nmi = 1'b0;
  logic       wt = 1'b0;
  logic       escape_coproc_instr = 1'b0;
  logic       intr = 1'b0;
  logic       xfer = 1'b0;
  logic       taken = 1'b0;
  logic       busy_c = 1'b0;
  logic       err_c = 1'b0;
  logic       req_c = 1'b0;
  wire logic  busy_n, error_n, req, ack_n, op_req, trap, inta, stall;
  wire logic  fetch, valid;
  wire logic [7:0] vec;
  int         n_mismatch = 0;
  int         check_count = 0;
  always #5 clk_in = ~clk_in;
  cnc_coproc i_cop (.clk_in(clk_in), .busy_cmd_in(busy_c),
    .err_cmd_in(err_c), .req_cmd_in(req_c), .busy_n_out(busy_n),
    .error_n_out(error_n), .req_out(req));
  cnc_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .nmi_in(nmi),
    .ext_operand_req_in(req), .busy_n_in(busy_n), .error_n_in(error_n),
    .ext_operand_ack_n_out(ack_n), .wait_instr_in(wt),
    .escape_coproc_instr_in(escape_coproc_instr), .intr_pending_in(intr),
    .operand_xfer_in(xfer), .trap_taken_in(taken),
    .operand_req_out(op_req), .trap_req_out(trap),
    .trap_vector_out(vec), .inta_cycle_out(inta), .stall_out(stall),
    .fetch_enable_out(fetch), .reset_valid_out(valid));
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic get_trap(input logic [7:0] v);
    for (int i = 0; i < 12 && trap !== 1'b1; i++) tick(1);
    chk(trap === 1'b1 && vec === v, "trap");
    if (trap !== 1'b1) report_and_stop();
    tick(2);
    taken = 1'b1;
    tick(1);
    taken = 1'b0;
    tick(1);
    chk(trap === 1'b0, "trap held");
  endtask
  task automatic t_reset();
    rst_in = 1'b1;
    tick(20);
    chk(!stall && !trap && ack_n === 1'b1, "reset");
    rst_in = 1'b0;
    tick(12);
    chk(valid === 1'b0, "valid early");
    tick(22);
    chk(valid === 1'b1 && fetch === 1'b0, "init");
    tick(8);
    chk(fetch === 1'b1, "no fetch");
    $display("reset test done");
  endtask
  task automatic t_nmi();
    nmi = 1'b1;
    get_trap(cnc_pkg::NMI_VECTOR);
    chk(inta === 1'b0, "ack cycle");
    nmi = 1'b0;
    tick(2);
    nmi = 1'b1;
    tick(8);
    chk(trap === 1'b0, "short low taken");
    nmi = 1'b0;
    tick(6);
    $display("nmi test done");
  endtask
  task automatic t_busy();
    busy_c = 1'b1;
    tick(4);
    wt = 1'b1;
    tick(3);
    chk(stall === 1'b1, "no stall");
    intr = 1'b1;
    wt = 1'b0;
    tick(3);
    chk(stall === 1'b0, "intr ignored");
    intr = 1'b0;
    wt = 1'b1;
    tick(3);
    busy_c = 1'b0;
    tick(6);
    chk(stall === 1'b0, "stall stuck");
    wt = 1'b0;
    $display("busy test done");
  endtask
  task automatic t_err();
    err_c = 1'b1;
    tick(4);
    escape_coproc_instr = 1'b1;
    tick(1);
    escape_coproc_instr = 1'b0; // One-cycle instruction; held high it re-arms the trap
    get_trap(cnc_pkg::COPROC_VECTOR);
    err_c = 1'b0;
    req_c = 1'b1;
    tick(3);
    chk(ack_n === 1'b1 && op_req === 1'b1, "req");
    xfer = 1'b1;
    tick(2);
    chk(ack_n === 1'b0, "no ack");
    xfer = 1'b0;
    tick(2);
    chk(ack_n === 1'b1, "ack stuck");
    req_c = 1'b0;
    $display("error and operand test done");
  endtask
  initial begin
    t_reset();
    t_nmi();
    t_busy();
    t_err();
    t_reset();
    report_and_stop();
  end
endmodule // tb
bind cnc_top cnc_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .nmi_in(nmi_in), .busy_n_in(busy_n_in), .error_n_in(error_n_in),
  .wait_instr_in(wait_instr_in),
  .escape_coproc_instr_in(escape_coproc_instr_in),
  .intr_pending_in(intr_pending_in), .operand_xfer_in(operand_xfer_in),
  .ext_operand_req_in(ext_operand_req_in),
  .ext_operand_ack_n_out(ext_operand_ack_n_out),
  .trap_req_out(trap_req_out), .trap_vector_out(trap_vector_out),
  .inta_cycle_out(inta_cycle_out), .stall_out(stall_out),
  .fetch_enable_out(fetch_enable_out));
`default_nettype wire
